// >>> include/ait_pkg.sv
// Package: register map, mux codes and timing constants
package ait_pkg;
    // Printed byte offsets; not all are multiples of four, so they are
    // register indices and the bus byte address is four times the index
    localparam logic [15:0] IDX_PCH = 16'h1D1F;
    localparam logic [15:0] IDX_NCH = 16'h1D20;
    localparam logic [15:0] IDX_ACQL = 16'h1D21;
    localparam logic [15:0] IDX_ACQH = 16'h1D22;
    localparam logic [15:0] IDX_CAP = 16'h1D23;
    localparam logic [15:0] IDX_PREL = 16'h1D24;
    localparam logic [15:0] IDX_PREH = 16'h1D25;
    localparam logic [15:0] IDX_REF = 16'h1D2B;
    // Own control/status registers
    localparam logic [15:0] IDX_CTRL = 16'h1D30;
    localparam logic [15:0] IDX_STAT = 16'h1D31;
    localparam int ADDR_W = 18;
    localparam int CNT_W = 13;
    localparam int CODE_W = 6;
    localparam int REG_W = 8;
    localparam int MEM_DEPTH = 16;
    localparam int MEM_AW = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;
    localparam logic [CODE_W-1:0] CODE_RST = 6'h00;
    localparam logic [1:0] REF_RST = 2'h0;
    localparam logic [4:0] CAP_RST = 5'h00;
    // Extended acquisition length when count is zero and precharge is not
    localparam logic [13:0] ACQ_LONG = 14'h2000;
    // Reference select codes
    localparam logic [1:0] REF_VDD = 2'h0;
    localparam logic [1:0] REF_RSVD = 2'h1;
    localparam logic [1:0] REF_EXT = 2'h2;
    localparam logic [1:0] REF_FVR = 2'h3;
    // Channel codes
    localparam logic [5:0] CH_FVR_BUF2 = 6'h3F;
    localparam logic [5:0] CH_FVR_BUF1 = 6'h3E;
    localparam logic [5:0] CH_DAC2 = 6'h3D;
    localparam logic [5:0] CH_DAC1 = 6'h3C;
    localparam logic [5:0] CH_TEMP = 6'h3B;
    localparam logic [5:0] CH_AGND = 6'h3A;
    localparam logic [5:0] CH_PC_LO = 6'h10;
    localparam logic [5:0] CH_PC_HI = 6'h17;
    localparam logic [5:0] CH_PB_LO = 6'h0C;
    localparam logic [5:0] CH_PB_HI = 6'h0F;
    localparam logic [5:0] CH_PA_HI = 6'h05;
    localparam logic [5:0] CH_GSENSE = 6'h03;
    // Mux select one-hot layout: 6 port A, 4 port B, 8 port C, ground sense, 6 internal, none
    localparam int SEL_W = 26;
    localparam int SEL_PA = 0;
    localparam int SEL_PB = 6;
    localparam int SEL_PC = 10;
    localparam int SEL_GSENSE = 18;
    localparam int SEL_AGND = 19;
    localparam int SEL_TEMP = 20;
    localparam int SEL_DAC1 = 21;
    localparam int SEL_DAC2 = 22;
    localparam int SEL_BUF1 = 23;
    localparam int SEL_BUF2 = 24;
    localparam int SEL_NONE = 25;
    // Control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_RCSEL = 1;
    // AHB
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_PRE,
        PH_ACQ,
        PH_CONV
    } ait_phase_t;
endpackage

// >>> src/ait_conv_ctrl.sv
// Converter input select and sample timing block with AHB-Lite registers
//
// What this block does
// - Reference field 11 fvr, 10 external, 00 supply
// - Top six channel codes select internal sources
// - Reserved channel codes connect nothing, both muxes
// - Port C, port B, port A, ground-sense mapping
// - Negative mux same, but 000011 connects nothing
// - Precharge lasts n clocks; zero skips it
// - Acquisition lasts n selected converter clocks
// - Acquisition zero, precharge nonzero: 8192 clocks
// - Counts split into high and low bytes
// - Channels, acquisition reset zero; bits 7:6 absent
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ait_conv_ctrl
    import ait_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ait_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Converter clock ticks from the dedicated RC oscillator domain
    input wire logic rcTickAsync,
    // Analog switch controls
    output logic [1:0] posRefSelect,
    output logic [ait_pkg::SEL_W-1:0] posMuxSel,
    output logic [ait_pkg::SEL_W-1:0] negMuxSel,
    output logic [4:0] capSelect,
    // Sample sequencing
    output logic [1:0] phase,
    output logic convStart,
    input wire logic convDone
);
    import ait_pkg::*;

    // Address phase capture
    logic wrPend_q;
    logic rdPend_q;
    logic [15:0] idx_q;
    logic accept;
    logic [15:0] aIdx;

    assign aIdx = haddr[ADDR_W-1:2];
    assign accept = hsel && hready && htrans == HTRANS_NONSEQ;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            idx_q <= 16'h0000;
        end else begin
            wrPend_q <= accept && hwrite;
            rdPend_q <= accept && !hwrite;
            if (accept) begin
                idx_q <= aIdx;
            end
        end
    end

    // Registers
    logic [CODE_W-1:0] pch_q;
    logic [CODE_W-1:0] nch_q;
    logic [CNT_W-1:0] acq_q;
    logic [CNT_W-1:0] pre_q;
    logic [1:0] ref_q;
    logic [4:0] cap_q;
    logic rcSel_q;
    logic start_q;
    logic [7:0] wb;

    assign wb = hwdata[7:0];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pch_q <= CODE_RST;
            nch_q <= CODE_RST;
            acq_q <= CNT_RST;
            pre_q <= CNT_RST;
            ref_q <= REF_RST;
            cap_q <= CAP_RST;
            rcSel_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wrPend_q) begin
                case (idx_q)
                    IDX_PCH: pch_q <= wb[5:0];
                    IDX_NCH: nch_q <= wb[5:0];
                    IDX_ACQL: acq_q[7:0] <= wb;
                    IDX_ACQH: acq_q[12:8] <= wb[4:0];
                    IDX_PREL: pre_q[7:0] <= wb;
                    IDX_PREH: pre_q[12:8] <= wb[4:0];
                    IDX_CAP: cap_q <= wb[4:0];
                    IDX_REF: ref_q <= wb[1:0];
                    IDX_CTRL: begin
                        rcSel_q <= wb[CTRL_RCSEL];
                        start_q <= wb[CTRL_START];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Read data
    ait_phase_t ph_q;
    logic [7:0] rdMux;

    always_comb begin
        rdMux = 8'h00;
        case (idx_q)
            IDX_PCH: rdMux = {2'b00, pch_q};
            IDX_NCH: rdMux = {2'b00, nch_q};
            IDX_ACQL: rdMux = acq_q[7:0];
            IDX_ACQH: rdMux = {3'b000, acq_q[12:8]};
            IDX_PREL: rdMux = pre_q[7:0];
            IDX_PREH: rdMux = {3'b000, pre_q[12:8]};
            IDX_CAP: rdMux = {3'b000, cap_q};
            IDX_REF: rdMux = {6'h00, ref_q};
            IDX_CTRL: rdMux = {6'h00, rcSel_q, 1'b0};
            IDX_STAT: rdMux = {6'h00, ph_q};
            default: rdMux = 8'h00;
        endcase
    end

    // Reads use the address captured in the address phase; the data
    // phase is combinational from registers so no wait state is needed
    // Outside a read data phase the bus sees zero, so a stale register
    // value never leaks onto a shared read mux
    assign hrdata = rdPend_q ? {24'h000000, rdMux} : 32'h00000000;

    // RC tick synchroniser and edge detect
    logic rcS1_q;
    logic rcS2_q;
    logic rcS3_q;
    logic rcTick;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rcS1_q <= 1'b0;
            rcS2_q <= 1'b0;
            rcS3_q <= 1'b0;
        end else begin
            rcS1_q <= rcTickAsync;
            rcS2_q <= rcS1_q;
            rcS3_q <= rcS2_q;
        end
    end

    assign rcTick = rcS2_q && !rcS3_q;

    // Converter clock enable: every system clock, or each RC rising edge
    logic convTick;
    assign convTick = rcSel_q ? rcTick : 1'b1;

    // Reference decode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            posRefSelect <= REF_VDD;
        end else begin
            // Reserved code keeps the supply rail as the safe choice
            posRefSelect <= (ref_q == REF_RSVD) ? REF_VDD : ref_q;
        end
    end

    // Channel decode shared by both muxes
    ait_mux_decode uPosDec (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .code(pch_q),
        .negative(1'b0),
        .sel(posMuxSel)
    );

    ait_mux_decode uNegDec (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .code(nch_q),
        .negative(1'b1),
        .sel(negMuxSel)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            capSelect <= CAP_RST;
        end else begin
            capSelect <= cap_q;
        end
    end

    // Sample sequencer
    logic [13:0] cnt_q;
    logic [13:0] acqLen;
    logic preOn;
    logic acqOn;
    logic busy;

    assign preOn = pre_q != CNT_RST;
    assign acqOn = (acq_q != CNT_RST) || preOn;
    assign acqLen = (acq_q == CNT_RST) ? ACQ_LONG : {1'b0, acq_q};
    assign busy = ph_q != PH_IDLE;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ph_q <= PH_IDLE;
            cnt_q <= 14'h0000;
            convStart <= 1'b0;
        end else begin
            convStart <= 1'b0;
            case (ph_q)
                PH_IDLE: begin
                    if (start_q) begin
                        if (preOn) begin
                            ph_q <= PH_PRE;
                            cnt_q <= {1'b0, pre_q};
                        end else if (acqOn) begin
                            ph_q <= PH_ACQ;
                            cnt_q <= acqLen;
                        end else begin
                            ph_q <= PH_CONV;
                            convStart <= 1'b1;
                        end
                    end
                end
                PH_PRE: begin
                    if (convTick) begin
                        if (cnt_q == 14'h0001) begin
                            ph_q <= PH_ACQ;
                            cnt_q <= acqLen;
                        end else begin
                            cnt_q <= cnt_q - 14'h0001;
                        end
                    end
                end
                PH_ACQ: begin
                    if (convTick) begin
                        if (cnt_q == 14'h0001) begin
                            ph_q <= PH_CONV;
                            convStart <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q - 14'h0001;
                        end
                    end
                end
                PH_CONV: begin
                    if (convDone) begin
                        ph_q <= PH_IDLE;
                    end
                end
                default: ph_q <= PH_IDLE;
            endcase
        end
    end

    assign phase = ph_q;

    // Checks
    a_pre_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!busy && start_q && !preOn) |=> ph_q != PH_PRE)
        else $error("precharge entered with zero count");
    a_acq_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!busy && start_q && !preOn && acq_q == CNT_RST)
        |=> ph_q == PH_CONV)
        else $error("acquisition not skipped");
    a_acq_long: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ph_q == PH_PRE && $past(ph_q) == PH_PRE && ph_q != PH_IDLE
        && convTick && cnt_q == 14'h0001 && acq_q == CNT_RST)
        |=> cnt_q == 14'h2000)
        else $error("long acquisition not loaded");
    a_pre_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!busy && start_q && preOn) |=> ph_q == PH_PRE)
        else $error("precharge not first");
    a_acq_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!busy && start_q && !preOn && acq_q == 13'h0002 && !rcSel_q)
        |=> ph_q == PH_ACQ ##1 ph_q == PH_ACQ ##1 ph_q == PH_CONV)
        else $error("acquisition length wrong");
    a_pre_rc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ph_q == PH_PRE && !convTick) |=> $stable(cnt_q))
        else $error("precharge counted without rc tick");
    a_ref_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ref_q == REF_FVR) |=> posRefSelect == REF_FVR)
        else $error("reference decode wrong");
    a_byte_split: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrPend_q && idx_q == IDX_ACQH) |=> acq_q[12:8] == $past(wb[4:0]))
        else $error("acquisition high byte not written");
    a_chan_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rdPend_q && idx_q == IDX_PCH) |-> hrdata[7:6] == 2'b00)
        else $error("channel select upper bits not zero");
    a_neg_gsense: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (nch_q == CH_GSENSE) |=> negMuxSel[SEL_NONE])
        else $error("negative mux connected ground sense");
    a_pos_rsvd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pch_q == 6'h20) |=> posMuxSel[SEL_NONE])
        else $error("reserved code connected a channel");
    a_pos_pc7: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pch_q == CH_PC_HI) |=> posMuxSel[SEL_PC+7])
        else $error("port C bit 7 not selected");
    a_pos_temp: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pch_q == CH_TEMP) |=> posMuxSel[SEL_TEMP])
        else $error("temperature source not selected");

    c_full_seq: cover property (@(posedge clk_sys)
        ph_q == PH_PRE ##1 ph_q == PH_ACQ);
    c_long_acq: cover property (@(posedge clk_sys)
        ph_q == PH_ACQ && cnt_q == 14'h2000);
    c_rc_run: cover property (@(posedge clk_sys)
        rcSel_q && ph_q == PH_ACQ && convTick);
    c_direct_conv: cover property (@(posedge clk_sys)
        ph_q == PH_IDLE ##1 ph_q == PH_CONV);
endmodule
`default_nettype wire

// >>> src/ait_mux_decode.sv
// Channel code to one-hot analog switch decoder
`timescale 1ns/1ps
`default_nettype none
module ait_mux_decode
    import ait_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Code and mux side
    input wire logic [ait_pkg::CODE_W-1:0] code,
    input wire logic negative,
    output logic [ait_pkg::SEL_W-1:0] sel
);
    import ait_pkg::*;

    logic [SEL_W-1:0] sel_d;

    always_comb begin
        sel_d = '0;
        if (code >= CH_PC_LO && code <= CH_PC_HI) begin
            sel_d[SEL_PC + int'(code[2:0])] = 1'b1;
        end else if (code >= CH_PB_LO && code <= CH_PB_HI) begin
            sel_d[SEL_PB + int'(code[1:0])] = 1'b1;
        end else if (code == CH_GSENSE) begin
            // Ground sense exists on the positive side only
            sel_d[negative ? SEL_NONE : SEL_GSENSE] = 1'b1;
        end else if (code <= CH_PA_HI) begin
            sel_d[SEL_PA + int'(code[2:0])] = 1'b1;
        end else begin
            case (code)
                CH_FVR_BUF2: sel_d[SEL_BUF2] = 1'b1;
                CH_FVR_BUF1: sel_d[SEL_BUF1] = 1'b1;
                CH_DAC2: sel_d[SEL_DAC2] = 1'b1;
                CH_DAC1: sel_d[SEL_DAC1] = 1'b1;
                CH_TEMP: sel_d[SEL_TEMP] = 1'b1;
                CH_AGND: sel_d[SEL_AGND] = 1'b1;
                default: sel_d[SEL_NONE] = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sel <= '0;
        end else begin
            sel <= sel_d;
        end
    end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking testbench for the converter input select and timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ait_pkg::*;
    logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans, posRefSelect, phase;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic rcTickAsync, convStart, convDone;
    logic [SEL_W-1:0] posMuxSel, negMuxSel;
    logic [4:0] capSelect;
    int rcDiv, nMismatch, nTests;

    assign hready = hreadyout;

    ait_conv_ctrl ait_conv_ctrl_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rcTickAsync(rcTickAsync),
        .posRefSelect(posRefSelect), .posMuxSel(posMuxSel),
        .negMuxSel(negMuxSel), .capSelect(capSelect), .phase(phase),
        .convStart(convStart), .convDone(convDone)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Free-running RC clock, one rising edge every six system clocks
    initial rcDiv = 0;
    always @(posedge clk_sys) begin
        rcDiv <= (rcDiv == 5) ? 0 : rcDiv + 1;
        rcTickAsync <= (rcDiv < 3);
    end

    task automatic close_out;
        if (nMismatch == 0 && nTests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        nTests++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One single AHB transfer; hrdata is taken at the closing edge
    task automatic bus(input logic [15:0] idx, input logic wr,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (hreadyout !== 1'b1) begin
            nMismatch++;
            close_out();
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(idx, 1'b1, d, x);
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] e,
                         input string nm);
        logic [31:0] x;
        bus(idx, 1'b0, 32'h0, x);
        chk(nm, x, e);
    endtask

    // Expected one-hot switch pattern worked out from the code table
    function automatic logic [31:0] expSel(input logic [5:0] c,
                                           input logic neg);
        int i;
        if (c >= CH_AGND) i = SEL_AGND + int'(c - CH_AGND);
        else if (c > CH_PC_HI) i = SEL_NONE;
        else if (c >= CH_PC_LO) i = SEL_PC + int'(c - CH_PC_LO);
        else if (c >= CH_PB_LO) i = SEL_PB + int'(c - CH_PB_LO);
        else if (c > CH_PA_HI) i = SEL_NONE;
        else if (c == CH_GSENSE) i = neg ? SEL_NONE : SEL_GSENSE;
        else i = SEL_PA + int'(c);
        return 32'h1 << i;
    endfunction

    task automatic t_reset;
        rdchk(IDX_PCH, 32'h0, "pos channel reset");
        rdchk(IDX_NCH, 32'h0, "neg channel reset");
        rdchk(IDX_ACQL, 32'h0, "acq low reset");
        rdchk(IDX_ACQH, 32'h0, "acq high reset");
        chk("posMuxSel reset", 32'(posMuxSel), 32'h1);
    endtask

    task automatic t_mux;
        for (int c = 0; c < 64; c++) begin
            wr(IDX_PCH, 32'(c));
            wr(IDX_NCH, 32'(c));
            repeat (2) @(posedge clk_sys);
            #1;
            chk("posMuxSel", 32'(posMuxSel), expSel(6'(c), 1'b0));
            chk("negMuxSel", 32'(negMuxSel), expSel(6'(c), 1'b1));
        end
        // Upper two bits are not stored
        wr(IDX_PCH, 32'hFF);
        rdchk(IDX_PCH, 32'h3F, "pos channel width");
        wr(IDX_NCH, 32'hC5);
        rdchk(IDX_NCH, 32'h05, "neg channel width");
    endtask

    task automatic t_ref;
        for (int r = 0; r < 4; r++) begin
            wr(IDX_REF, 32'(r));
            repeat (2) @(posedge clk_sys);
            #1;
            chk("posRefSelect", 32'(posRefSelect), (r == 1) ? 0 : r);
        end
    endtask

    task automatic t_halves;
        wr(IDX_ACQL, 32'hA5);
        wr(IDX_ACQH, 32'hFF);
        rdchk(IDX_ACQL, 32'hA5, "acq low byte");
        rdchk(IDX_ACQH, 32'h1F, "acq high byte");
        wr(IDX_PREH, 32'h0E);
        wr(IDX_PREL, 32'h3C);
        rdchk(IDX_PREH, 32'h0E, "pre high byte");
        rdchk(IDX_PREL, 32'h3C, "pre low byte");
        // Unmapped place reads zero and ignores writes
        wr(16'h1D26, 32'hFF);
        rdchk(16'h1D26, 32'h0, "unmapped read");
        // Capacitor field keeps five bits and is copied to its switch port
        wr(IDX_CAP, 32'h35);
        rdchk(IDX_CAP, 32'h15, "cap width");
        chk("capSelect", 32'(capSelect), 32'h15);
        chk("hresp", 32'(hresp), 32'h0);
    endtask

    // Run one sample and time each phase in system clocks
    task automatic t_seq(input logic [12:0] pre, acquisition_count, input logic rc,
                         input int ePre, eAcq);
        int nPre, nAcq, k, m;
        logic bad;
        nPre = 0;
        nAcq = 0;
        bad = 1'b0;
        wr(IDX_PREL, 32'(pre[7:0]));
        wr(IDX_PREH, 32'(pre[12:8]));
        wr(IDX_ACQL, 32'(acquisition_count[7:0]));
        wr(IDX_ACQH, 32'(acquisition_count[12:8]));
        wr(IDX_CTRL, {30'h0, rc, 1'b1});
        for (k = 0; k < 30000 && phase !== 2'h3; k++) begin
            @(posedge clk_sys);
            #1;
            if (phase === 2'h1) begin
                nPre++;
                if (nAcq > 0) bad = 1'b1;
            end
            if (phase === 2'h2) nAcq++;
        end
        if (phase !== 2'h3) begin
            nMismatch++;
            close_out();
        end
        chk("convStart", 32'(convStart), 32'h1);
        chk("phase order", 32'(bad), 32'h0);
        if (rc) begin
            m = 6 * ePre;
            chk("rc precharge", 32'(nPre >= m - 6 && nPre <= m + 6), 1);
            m = 6 * eAcq;
            chk("rc acquisition", 32'(nAcq >= m - 6 && nAcq <= m + 6), 1);
        end else begin
            chk("precharge clocks", nPre, ePre);
            chk("acquisition clocks", nAcq, eAcq);
        end
        @(posedge clk_sys);
        convDone <= 1'b1;
        @(posedge clk_sys);
        convDone <= 1'b0;
        for (k = 0; k < 20 && phase !== 2'h0; k++) @(posedge clk_sys);
        #1;
        chk("phase after done", 32'(phase), 32'h0);
        chk("convStart after done", 32'(convStart), 32'h0);
    endtask

    initial begin
        nMismatch = 0;
        nTests = 0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        convDone = 1'b0;
        rcTickAsync = 1'b0;
        rst_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        t_reset();
        t_mux();
        t_ref();
        t_halves();
        t_seq(13'h0001, 13'h0002, 1'b0, 1, 2);
        t_seq(13'h0000, 13'h0003, 1'b0, 0, 3);
        t_seq(13'h0000, 13'h0000, 1'b0, 0, 0);
        t_seq(13'h0004, 13'h0000, 1'b0, 4, 8192);
        t_seq(13'h0003, 13'h0002, 1'b1, 3, 2);
        close_out();
    end
endmodule
`default_nettype wire
